/* bench/sei_host.sv */
// Host model: issues register reads and writes on the request port.
// Assumes the port samples requests at the rising edge of clk_i.
`timescale 1ns/1ns
module sei_host (
  input  wire logic         clk_i,
  output sei_pkg::sei_req_s req_o
);
  import sei_pkg::*;
  initial req_o = '0;
  // One-cycle strobe, then idle
  task automatic xfer(input logic w, input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask
endmodule // sei_host

/* bench/testbench.sv */
// Self-checking bench for the edge interrupt enable register.
// Assumes sei_host drives requests; comparator levels driven here.
`timescale 1ns/1ns
module testbench;
  import sei_pkg::*;
  logic        clk;
  logic        rst;
  sei_req_s    req;
  sei_cmp_s    cmp;
  sei_cmp_s    prv;
  sei_cmp_s    cur;
  sei_cmp_s    nx;
  logic [23:0] rdata;
  logic [23:0] reg_v;
  logic        rvalid;
  logic [5:0]  ea;
  logic [5:0]  eb;
  logic [31:0] seed = 32'hE159C4FD;
  int          err_total;
  int          samples_checked;
  sei_edge_irq_enable i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req), .CMP_I(cmp),
    .RDATA_O(rdata), .RVALID_O(rvalid), .EVT_A_O(ea), .EVT_B_O(eb));
  sei_host i_host (.clk_i(clk), .req_o(req));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bit s of a field flags rising, bit s+1 falling
  function automatic logic [23:0] ev(input logic [5:0] p, c, input logic [23:0] r, input int s);
    ev = '0;
    for (int i = 0; i < 6; i++)
      ev[i] = (!p[i] && c[i] && r[4*i+s]) || (p[i] && !c[i] && r[4*i+s+1]);
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] v);
    samples_checked++;
    if (v !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    i_host.xfer(1'b0, a, 24'h0);
    #1;
    chk("rvalid", 24'h1, 24'(rvalid));
    chk("rdata", e, rdata);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    cmp = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(6'h26, 24'h0);
    i_host.xfer(1'b1, 6'h25, 24'hFFFFFF);
    rd(6'h25, 24'h0);
    rd(6'h26, 24'h0);
    $display("test reset_and_map done");
    for (int k = 0; k < 21; k++) begin
      case (k)
        0: reg_v = 24'h000000;
        1: reg_v = 24'h555555;
        2: reg_v = 24'hAAAAAA;
        3: reg_v = 24'hFFFFFF;
        4: reg_v = 24'h111111;
        default: reg_v = 24'(rnd());
      endcase
      i_host.xfer(1'b1, 6'h26, reg_v);
      rd(6'h26, reg_v);
      prv = cmp;
      cur = cmp;
      repeat (24) begin
        @(posedge clk);
        nx = sei_cmp_s'(12'(rnd()));
        cmp <= nx;
        #1;
        chk("evt_a", ev(prv.above_a, cur.above_a, reg_v, 0), 24'(ea));
        chk("evt_b", ev(prv.above_b, cur.above_b, reg_v, 2), 24'(eb));
        chk("rvalid_idle", 24'h0, 24'(rvalid));
        chk("rdata_idle", 24'h0, rdata);
        prv = cur;
        cur = nx;
      end
    end
    $display("test edge_events done");
    i_host.xfer(1'b1, 6'h26, 24'h5A5A5A);
    rd(6'h26, 24'h5A5A5A);
    @(posedge clk);
    rst <= 1'b1;
    cmp <= '1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(6'h26, SEI_REG_RESET);
    chk("evt_a", 24'h0, 24'(ea));
    chk("evt_b", 24'h0, 24'(eb));
    $display("test mid_reset done");
    summarize();
  end
endmodule // testbench

/* logic/sei_edge_irq_enable.sv */
// Edge interrupt enable register for switch inputs 12 to 17 and its edge detectors.
// Assumes host port decoded upstream; comparator levels synchronous to REF_CLK_I.
//
// Operation
// - Inputs 17, 16, 15 use bits 23:20, 19:16, 15:12.
// - Inputs 14, 13, 12 use bits 11:8, 7:4, 3:0.
// - Low selector 00 disables threshold A; 01 flags rising crossing of A.
// - Low selector 10 flags falling crossing of A; 11 flags both.
// - High selector 00 disables threshold B; 01 flags rising crossing of B.
// - High selector 10 flags falling crossing of B; 11 flags both.
// - All fields read and write, reset to zero, nothing enabled.
// - Register sits at offset 26h, reset value zero.
`timescale 1ns/1ns
module sei_edge_irq_enable (
  input  wire logic                         REF_CLK_I,
  input  wire logic                         SYS_RST_I,
  input  wire sei_pkg::sei_req_s            REQ_I,
  input  wire sei_pkg::sei_cmp_s            CMP_I,
  output logic [sei_pkg::SEI_REG_W-1:0]     RDATA_O,
  output logic                              RVALID_O,
  output logic [sei_pkg::SEI_NUM_IN-1:0]    EVT_A_O,
  output logic [sei_pkg::SEI_NUM_IN-1:0]    EVT_B_O
);
  import sei_pkg::*;

  logic [SEI_REG_W-1:0]  enable_r;
  logic [SEI_REG_W-1:0]  enable_nxt;
  logic [SEI_NUM_IN-1:0] above_a_r;
  logic [SEI_NUM_IN-1:0] above_b_r;
  logic                  cmp_valid_r;
  logic [SEI_NUM_IN-1:0] evt_a_nxt;
  logic [SEI_NUM_IN-1:0] evt_b_nxt;
  logic                  hit;
  logic                  wr_hit;
  logic                  rd_hit;

  // Address decode
  assign hit        = (REQ_I.addr == SEI_REG_OFFSET);
  assign wr_hit     = REQ_I.wr && hit;
  assign rd_hit     = REQ_I.rd && hit;
  assign enable_nxt = wr_hit ? REQ_I.wdata : enable_r;

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      enable_r <= SEI_REG_RESET;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  property p_reset_value;
    @(posedge REF_CLK_I)
      SYS_RST_I |=> enable_r == SEI_REG_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("enable register not cleared by reset");

  // Readback; unmapped offsets read zero
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O  <= '0;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= REQ_I.rd;
      RDATA_O  <= rd_hit ? enable_r : '0;
    end
  end

  property p_idle_read_quiet;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !REQ_I.rd |=> !RVALID_O && RDATA_O == '0;
  endproperty
  a_idle_read_quiet: assert property (p_idle_read_quiet)
    else $error("read answer without a read");

  property p_miss_reads_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.rd && !hit) |=> RVALID_O && RDATA_O == '0;
  endproperty
  a_miss_reads_zero: assert property (p_miss_reads_zero)
    else $error("read of other offset returned data");

  // Previous comparator levels; first sample after reset raises nothing
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      above_a_r   <= '0;
      above_b_r   <= '0;
      cmp_valid_r <= 1'b0;
    end else begin
      above_a_r   <= CMP_I.above_a;
      above_b_r   <= CMP_I.above_b;
      cmp_valid_r <= 1'b1;
    end
  end

  property p_first_sample_quiet;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !cmp_valid_r |=> EVT_A_O == '0 && EVT_B_O == '0;
  endproperty
  a_first_sample_quiet: assert property (p_first_sample_quiet)
    else $error("event raised from first sample after reset");

  property p_steady_quiet;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (CMP_I.above_a == above_a_r && CMP_I.above_b == above_b_r)
        |=> EVT_A_O == '0 && EVT_B_O == '0;
  endproperty
  a_steady_quiet: assert property (p_steady_quiet)
    else $error("event raised without a crossing");

  // Per input edge qualification
  genvar gi;
  generate
    for (gi = 0; gi < SEI_NUM_IN; gi++) begin : g_in
      localparam int LSB = gi * SEI_FLD_W;
      wire [1:0] sel_a = enable_r[LSB+SEI_SEL_A_LSB +: 2];
      wire [1:0] sel_b = enable_r[LSB+SEI_SEL_B_LSB +: 2];
      wire rise_a = cmp_valid_r && CMP_I.above_a[gi] && !above_a_r[gi];
      wire fall_a = cmp_valid_r && !CMP_I.above_a[gi] && above_a_r[gi];
      wire rise_b = cmp_valid_r && CMP_I.above_b[gi] && !above_b_r[gi];
      wire fall_b = cmp_valid_r && !CMP_I.above_b[gi] && above_b_r[gi];
      // Bit 0 of a selector enables rising, bit 1 falling
      assign evt_a_nxt[gi] = (sel_a[0] && rise_a) || (sel_a[1] && fall_a);
      assign evt_b_nxt[gi] = (sel_b[0] && rise_b) || (sel_b[1] && fall_b);
    end
  endgenerate

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      EVT_A_O <= '0;
      EVT_B_O <= '0;
    end else begin
      EVT_A_O <= evt_a_nxt;
      EVT_B_O <= evt_b_nxt;
    end
  end

  // Checks
  property p_write_stores;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      wr_hit |=> enable_r == $past(REQ_I.wdata);
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("enable register did not take write");

  property p_other_addr_keeps;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (REQ_I.wr && !hit) |=> $stable(enable_r);
  endproperty
  a_other_addr_keeps: assert property (p_other_addr_keeps)
    else $error("write to other offset changed register");

  property p_readback;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      rd_hit |=> RVALID_O && RDATA_O == $past(enable_r);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch");

  property p_a_rise_17;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[21:20] == 2'b01 && cmp_valid_r && CMP_I.above_a[5] && !above_a_r[5])
        |=> EVT_A_O[5];
  endproperty
  a_a_rise_17: assert property (p_a_rise_17)
    else $error("input 17 rising A missed");

  property p_a_none;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[1:0] == 2'b00) |=> !EVT_A_O[0];
  endproperty
  a_a_none: assert property (p_a_none)
    else $error("input 12 A event while disabled");

  property p_a_fall_only;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[9:8] == 2'b10 && CMP_I.above_a[2] && !above_a_r[2]) |=> !EVT_A_O[2];
  endproperty
  a_a_fall_only: assert property (p_a_fall_only)
    else $error("falling-only selector fired on rise");

  property p_b_both_16;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[19:18] == 2'b11 && cmp_valid_r && CMP_I.above_b[4] != above_b_r[4])
        |=> EVT_B_O[4];
  endproperty
  a_b_both_16: assert property (p_b_both_16)
    else $error("input 16 B both-edge missed");

  property p_b_indep;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[7:6] == 2'b00 && enable_r[5:4] == 2'b01
        && cmp_valid_r && CMP_I.above_a[1] && !above_a_r[1]) |=> EVT_A_O[1] && !EVT_B_O[1];
  endproperty
  a_b_indep: assert property (p_b_indep)
    else $error("threshold selectors not independent");

  property p_a_fall_14;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[9:8] == 2'b10 && cmp_valid_r && !CMP_I.above_a[2] && above_a_r[2])
        |=> EVT_A_O[2];
  endproperty
  a_a_fall_14: assert property (p_a_fall_14)
    else $error("input 14 falling A missed");

  property p_a_both_12;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[1:0] == 2'b11 && cmp_valid_r && CMP_I.above_a[0] != above_a_r[0])
        |=> EVT_A_O[0];
  endproperty
  a_a_both_12: assert property (p_a_both_12)
    else $error("input 12 A both-edge missed");

  property p_b_none_15;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[15:14] == 2'b00) |=> !EVT_B_O[3];
  endproperty
  a_b_none_15: assert property (p_b_none_15)
    else $error("input 15 B event while disabled");

  property p_b_rise_16;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[19:18] == 2'b01 && cmp_valid_r && CMP_I.above_b[4] && !above_b_r[4])
        |=> EVT_B_O[4];
  endproperty
  a_b_rise_16: assert property (p_b_rise_16)
    else $error("input 16 rising B missed");

  property p_b_rise_only_16;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[19:18] == 2'b01 && !CMP_I.above_b[4] && above_b_r[4]) |=> !EVT_B_O[4];
  endproperty
  a_b_rise_only_16: assert property (p_b_rise_only_16)
    else $error("input 16 rising-only selector fired on fall");

  property p_b_fall_17;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (enable_r[23:22] == 2'b10 && cmp_valid_r && !CMP_I.above_b[5] && above_b_r[5])
        |=> EVT_B_O[5];
  endproperty
  a_b_fall_17: assert property (p_b_fall_17)
    else $error("input 17 falling B missed");
endmodule // sei_edge_irq_enable

/* logic/sei_pkg.sv */
// Package for the second-bank switch edge interrupt enable register.
// Assumes a single 25 MHz clock and a word-wide register access port.
package sei_pkg;
  localparam int           SEI_NUM_IN      = 6;
  localparam int           SEI_FLD_W       = 4;
  localparam int           SEI_REG_W       = 24;
  localparam int           SEI_ADDR_W      = 6;
  localparam logic [5:0]   SEI_REG_OFFSET  = 6'h26;
  localparam logic [23:0]  SEI_REG_RESET   = 24'h000000;
  localparam int           SEI_SEL_A_LSB   = 0;
  localparam int           SEI_SEL_B_LSB   = 2;
  localparam int           SEI_FIRST_INPUT = 12;

  typedef enum logic [1:0] {
    SEI_EDGE_NONE = 2'b00,
    SEI_EDGE_RISE = 2'b01,
    SEI_EDGE_FALL = 2'b10,
    SEI_EDGE_BOTH = 2'b11
  } sei_edge_e;

  // Register access request from the serial host port
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [SEI_ADDR_W-1:0] addr;
    logic [SEI_REG_W-1:0]  wdata;
  } sei_req_s;

  // Comparator levels per input, one bit per threshold
  typedef struct packed {
    logic [SEI_NUM_IN-1:0] above_b;
    logic [SEI_NUM_IN-1:0] above_a;
  } sei_cmp_s;
endpackage : sei_pkg
